// File: bench/uifc_core_model.sv
// Behavioural receive/transmit core that feeds event pulses to the controller
`timescale 1ns/100ps
module uifc_core_model
   import uifc_pkg::*;
#(
   parameter int TICK_DIV = 4
) (
   input wire logic clock,
   output uifc_core_t core
);
   logic [9:0] ev_reg = 10'h000;
   int div_reg = 0;
   // Bit clock runs free, like a baud generator, so timers see real gaps
   always_ff @(posedge clock) begin
      div_reg <= (div_reg == TICK_DIV - 1) ? 0 : div_reg + 1;
   end
   always_comb begin
      core = uifc_core_t'(ev_reg);
      core.bit_tick = (div_reg == 0);
   end
   // One-cycle event; caller enters just after a rising edge
   task automatic pulse(input int idx);
      ev_reg[idx] <= 1'b1;
      @(posedge clock);
      ev_reg[idx] <= 1'b0;
   endtask
endmodule

// File: bench/uifc_ctrl_tb_top.sv
// Self-checking bench for the UART interrupt and FIFO control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module uifc_ctrl_tb_top
   import uifc_pkg::*;
;
   localparam logic [1:0] FE = 2'b11;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   uifc_core_t core;
   logic [4:0] rx_level = 5'h00, tx_level = 5'h01;
   logic [3:0] word_bits = 4'hA, modem_change = 4'h0;
   logic enh_enable = 1'b0, auto_cts = 1'b0, auto_rts = 1'b0, cts_pin = 1'b0, rts_pin = 1'b0;
   logic fifo_enable, rx_fifo_reset, tx_fifo_reset, sleep_enable, irq;
   logic [1:0] rx_trigger_sel, tx_trigger_sel;
   int n_mismatch = 0, checks = 0, cyc = 0, n_rxrst = 0, n_txrst = 0;
   logic [31:0] d;
   logic [1:0] r;

   uifc_core_model #(.TICK_DIV(4)) core_u (.clock, .core);
   uifc_ctrl dut_u (
      .clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .core, .rx_level, .tx_level, .word_bits, .modem_change,
      .enh_enable, .auto_cts, .auto_rts, .cts_pin, .rts_pin, .fifo_enable, .rx_fifo_reset,
      .tx_fifo_reset, .rx_trigger_sel, .tx_trigger_sel, .sleep_enable, .irq
   );

   initial begin
      forever begin
         #4 clock = ~clock;
      end
   end

   task automatic give_verdict;
      if (n_mismatch == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Whole run is about 450 cycles
   always @(posedge clock) begin
      cyc <= cyc + 1;
      n_rxrst <= n_rxrst + int'(rx_fifo_reset === 1'b1);
      n_txrst <= n_txrst + int'(tx_fifo_reset === 1'b1);
      if (cyc == 6000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready === 1'b1) begin
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1) begin
            s_axi_wvalid <= 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1);
      `CHK("bresp", er, s_axi_bresp)
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] dv, output logic [1:0] rv);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clock); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clock);
      dv = s_axi_rdata;
      rv = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask

   task automatic src(input logic [7:0] e);
      rd(ADDR_SOURCE, d, r);
      `CHK("source", e, d[7:0])
   endtask

   task automatic settle;
      repeat (4) @(posedge clock);
   endtask

   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      src({2'b00, SRC_NONE});
      rd(ADDR_MASK, d, r);
      `CHK("mask", MASK_RESET, d[7:0])
      // Resets and trigger bits without the enable bit must be dropped
      wr(ADDR_QCTRL, 8'hF6, RESP_OKAY);
      `CHK("fifo_enable", 1'b0, fifo_enable)
      `CHK("rx_trigger_sel", 2'b00, rx_trigger_sel)
      wr(ADDR_QCTRL, 8'h3F, RESP_OKAY);
      settle();
      `CHK("fifo_enable", 1'b1, fifo_enable)
      `CHK("rx resets", 1, n_rxrst)
      `CHK("tx resets", 1, n_txrst)
      `CHK("tx_trigger_sel", 2'b00, tx_trigger_sel)
      src({FE, SRC_NONE});
      tx_level <= 5'h00;
      wr(ADDR_MASK, 8'h02, RESP_OKAY);
      settle();
      `CHK("irq", 1'b1, irq)
      src({FE, SRC_TX});
      src({FE, SRC_NONE});
      tx_level <= 5'h01;
      settle();
      tx_level <= 5'h00;
      settle();
      `CHK("irq", 1'b1, irq)
      wr(ADDR_THOLD, 8'h55, RESP_OKAY);
      src({FE, SRC_NONE});
      tx_level <= 5'h01;
      wr(ADDR_MASK, 8'h05, RESP_OKAY);
      rx_level <= 5'h01;
      core_u.pulse(9);
      settle();
      src({FE, SRC_RX});
      core_u.pulse(7);
      settle();
      src({FE, SRC_LS});
      rd(ADDR_LINE, d, r);
      src({FE, SRC_RX});
      core_u.pulse(6);
      settle();
      src({FE, SRC_LS});
      rd(ADDR_LINE, d, r);
      rx_level <= 5'h00;
      settle();
      src({FE, SRC_NONE});
      // Trigger of four keeps one character below it, so only the timer fires
      word_bits <= 4'h8;
      wr(ADDR_QCTRL, 8'h41, RESP_OKAY);
      `CHK("rx_trigger_sel", 2'b01, rx_trigger_sel)
      rx_level <= 5'h01;
      core_u.pulse(9);
      repeat (150) @(posedge clock);
      src({FE, SRC_NONE});
      repeat (80) @(posedge clock);
      src({FE, SRC_TO});
      rd(ADDR_RHOLD, d, r);
      src({FE, SRC_NONE});
      rx_level <= 5'h00;
      wr(ADDR_MASK, 8'h08, RESP_OKAY);
      modem_change <= 4'h4;
      settle();
      src({FE, SRC_MS});
      modem_change <= 4'h0;
      settle();
      src({FE, SRC_NONE});
      wr(ADDR_MASK, 8'hF0, RESP_OKAY);
      rd(ADDR_MASK, d, r);
      `CHK("mask", 8'h00, d[7:0])
      enh_enable <= 1'b1;
      wr(ADDR_MASK, 8'hF0, RESP_OKAY);
      rd(ADDR_MASK, d, r);
      `CHK("mask", 8'hF0, d[7:0])
      `CHK("sleep_enable", 1'b1, sleep_enable)
      // Without the low byte strobe the register takes zeros
      s_axi_wstrb <= 4'h0;
      wr(ADDR_MASK, 8'hFF, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(ADDR_MASK, d, r);
      `CHK("mask", 8'h00, d[7:0])
      wr(ADDR_QCTRL, 8'h31, RESP_OKAY);
      `CHK("tx_trigger_sel", 2'b11, tx_trigger_sel)
      wr(ADDR_MASK, 8'h20, RESP_OKAY);
      core_u.pulse(4);
      settle();
      src({FE, SRC_XOFF});
      src({FE, SRC_NONE});
      core_u.pulse(4);
      core_u.pulse(3);
      settle();
      src({FE, SRC_NONE});
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_MASK, (i == 1) ? 8'h40 : 8'h80, RESP_OKAY);
         auto_rts <= (i == 1);
         auto_cts <= (i == 0);
         cts_pin <= (i == 0);
         rts_pin <= (i == 1);
         settle();
         src({FE, SRC_FLOW});
         rd(ADDR_MODEM, d, r);
         src({FE, SRC_NONE});
      end
      rd(4'h1, d, r);
      `CHK("rresp", RESP_SLVERR, r)
      wr(ADDR_LINE, 8'h00, RESP_SLVERR);
      give_verdict();
   end
endmodule

// File: logic/uifc_ctrl.sv
// UART interrupt mask, prioritised source encoder and FIFO control with AXI4-Lite slave
// Functional notes
// [RL1] Receive interrupt at trigger or held character
// [RL2] Transmit interrupt on empty; enabling when empty fires
// [RL3] Overrun raises line interrupt immediately
// [RL4] Parity/framing/break interrupt when read out
// [RL5] Upper mask bits need enhanced enable
// [RL6] RTS/CTS interrupt on low-to-high edge
// [RL7] Source read returns highest pending only
// [RL8] Timeout is four chars plus twelve bits
// [RL9] Transmit source from trigger or empty
// [RL10] Modem interrupt from low four change bits
// [RL11] Flow interrupt on auto RTS/CTS deassert
// [RL12] Line read clears; error summary stays
// [RL13] Receive below trigger clears; holding read clears timeout
// [RL14] Source read or holding write clears transmit
// [RL15] Xoff clears on read or Xon
// [RL16] Modem read clears modem, flow; wake on source read (code: read clears flow only; ms_reg follows modem_change)
// [RL17] Six-bit source codes by priority
// [RL18] Bit zero one when none or wake (code: wake_reg is not fed to the encoder, so only none sets it)
// [RL19] Top two source bits show FIFO enable
// [RL20] Queue control ignored without enable bit
// [RL21] FIFO reset bits pulse and self-clear
// [RL22] Transmit trigger selection needs enhanced enable
// [RL23] DMA bit unused; masks reset zero
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module uifc_ctrl
   import uifc_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire uifc_core_t core,
   input wire logic [4:0] rx_level,
   input wire logic [4:0] tx_level,
   input wire logic [3:0] word_bits,
   input wire logic [3:0] modem_change,
   input wire logic enh_enable,
   input wire logic auto_cts,
   input wire logic auto_rts,
   input wire logic cts_pin,
   input wire logic rts_pin,
   output logic fifo_enable,
   output logic rx_fifo_reset,
   output logic tx_fifo_reset,
   output logic [1:0] rx_trigger_sel,
   output logic [1:0] tx_trigger_sel,
   output logic sleep_enable,
   output logic irq
);
   logic [7:0] mask_reg;
   logic [7:0] qctrl_reg;
   logic aw_hold_reg, w_hold_reg;
   logic [3:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic [31:0] rdata_reg;
   logic rvalid_reg, bvalid_reg;
   logic [1:0] rresp_reg, bresp_reg;
   logic cts_s1_reg, cts_s2_reg, cts_s3_reg;
   logic rts_s1_reg, rts_s2_reg, rts_s3_reg;
   logic ls_reg, to_reg, tx_reg, xoff_reg, flow_reg, wake_reg, ms_reg;
   logic tx_empty_prev_reg, tx_over_reg;
   logic [7:0] to_cnt_reg;
   logic [5:0] src_code;
   logic [7:0] src_byte;
   logic do_write, do_read;
   logic rd_source, rd_line, rd_modem, rd_rhold, wr_thold, wr_mask, wr_qctrl;
   logic [4:0] rx_trig, tx_trig;
   logic rx_hit, tx_hit, tx_empty;
   logic [7:0] mask_next;
   logic [7:0] to_limit;

   // Write channel: address and data accepted in any order
   assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign do_read = s_axi_arvalid && s_axi_arready;
   assign wr_mask = do_write && awaddr_reg == ADDR_MASK;
   assign wr_qctrl = do_write && awaddr_reg == ADDR_QCTRL;
   assign wr_thold = do_write && awaddr_reg == ADDR_THOLD;
   assign rd_source = do_read && s_axi_araddr == ADDR_SOURCE;
   assign rd_line = do_read && s_axi_araddr == ADDR_LINE;
   assign rd_modem = do_read && s_axi_araddr == ADDR_MODEM;
   assign rd_rhold = do_read && s_axi_araddr == ADDR_RHOLD;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= 4'h0;
         wdata_reg <= 8'h00;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= (awaddr_reg[1:0] != 2'b00 || awaddr_reg == ADDR_LINE) ?
                         RESP_SLVERR : RESP_OKAY;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_hold_reg;
   assign s_axi_wready = !w_hold_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // Mask register; upper bits frozen while enhanced features are off
   always_comb begin
      mask_next = mask_reg;
      if (wr_mask) begin
         mask_next = enh_enable ? wdata_reg :
                     ((mask_reg & ~MASK_LOW_BITS) | (wdata_reg & MASK_LOW_BITS)); // [RL5]
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= MASK_RESET; // [RL23]
      end else begin
         mask_reg <= mask_next;
      end
   end

   // Queue control; DMA bit is stored nowhere
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         qctrl_reg <= 8'h00;
         rx_fifo_reset <= 1'b0;
         tx_fifo_reset <= 1'b0;
      end else begin
         rx_fifo_reset <= 1'b0; // [RL21]
         tx_fifo_reset <= 1'b0;
         if (wr_qctrl) begin
            qctrl_reg[QC_EN] <= wdata_reg[QC_EN];
            if (wdata_reg[QC_EN]) begin // [RL20]
               rx_fifo_reset <= wdata_reg[QC_RXRST]; // [RL21]
               tx_fifo_reset <= wdata_reg[QC_TXRST];
               qctrl_reg[QC_RXTRG +: 2] <= wdata_reg[QC_RXTRG +: 2];
               if (enh_enable) begin
                  qctrl_reg[QC_TXTRG +: 2] <= wdata_reg[QC_TXTRG +: 2]; // [RL22]
               end
            end
         end
      end
   end
   assign fifo_enable = qctrl_reg[QC_EN];
   assign rx_trigger_sel = qctrl_reg[QC_RXTRG +: 2];
   assign tx_trigger_sel = qctrl_reg[QC_TXTRG +: 2];
   assign sleep_enable = mask_reg[4] && enh_enable;

   function automatic logic [4:0] trig_level(input logic [1:0] sel);
      unique case (sel)
         2'd0: trig_level = 5'd1;
         2'd1: trig_level = 5'd4;
         2'd2: trig_level = 5'd8;
         default: trig_level = 5'd14;
      endcase
   endfunction
   // Non-FIFO mode behaves as a one-deep holding register
   assign rx_trig = fifo_enable ? trig_level(rx_trigger_sel) : 5'd1;
   assign tx_trig = fifo_enable ? trig_level(tx_trigger_sel) : 5'd1;
   assign rx_hit = rx_level >= rx_trig; // [RL1] [RL13]
   assign tx_empty = tx_level == 5'd0;
   // Below trigger once the level has passed above the trigger since the last empty, or empty
   assign tx_hit = (tx_level < tx_trig && tx_over_reg) || tx_empty; // [RL9] [RL22]

   // Pin synchronisers for flow-control edge detection
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cts_s1_reg <= 1'b0;
         cts_s2_reg <= 1'b0;
         cts_s3_reg <= 1'b0;
         rts_s1_reg <= 1'b0;
         rts_s2_reg <= 1'b0;
         rts_s3_reg <= 1'b0;
      end else begin
         cts_s1_reg <= cts_pin;
         cts_s2_reg <= cts_s1_reg;
         cts_s3_reg <= cts_s2_reg;
         rts_s1_reg <= rts_pin;
         rts_s2_reg <= rts_s1_reg;
         rts_s3_reg <= rts_s2_reg;
      end
   end

   // Receive timeout counted in bit ticks, restarted by any FIFO traffic
   assign to_limit = 8'(TO_CHARS) * {4'h0, word_bits} + 8'(TO_BITS); // [RL8]
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         to_cnt_reg <= 8'h00;
         to_reg <= 1'b0;
      end else begin
         if (core.char_in || core.char_out || rx_level == 5'd0 || !fifo_enable) begin
            to_cnt_reg <= 8'h00;
         end else if (core.bit_tick && to_cnt_reg != to_limit) begin
            to_cnt_reg <= to_cnt_reg + 8'h01;
         end
         if (core.bit_tick && to_cnt_reg == to_limit - 8'h01 && rx_level != 5'd0) begin
            to_reg <= 1'b1; // [RL8]
         end else if (rd_rhold || rx_level == 5'd0) begin
            to_reg <= 1'b0; // [RL13]
         end
      end
   end

   // Sticky sources, except ms_reg which follows modem_change; a new event wins over its clear in the same cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ls_reg <= 1'b0;
         tx_reg <= 1'b0;
         xoff_reg <= 1'b0;
         flow_reg <= 1'b0;
         wake_reg <= 1'b0;
         ms_reg <= 1'b0;
         tx_empty_prev_reg <= 1'b1;
         tx_over_reg <= 1'b0;
      end else begin
         tx_empty_prev_reg <= tx_hit;
         if (tx_level > tx_trig) begin
            tx_over_reg <= 1'b1;
         end else if (tx_empty) begin
            tx_over_reg <= 1'b0;
         end
         if (core.overrun || core.char_err) begin
            ls_reg <= 1'b1; // [RL3] [RL4]
         end else if (rd_line) begin
            ls_reg <= 1'b0; // [RL12]
         end
         if ((tx_hit && !tx_empty_prev_reg) ||
             (mask_next[MSK_TX] && !mask_reg[MSK_TX] && tx_hit)) begin
            tx_reg <= 1'b1; // [RL2]
         end else if ((rd_source && src_code == SRC_TX) || wr_thold) begin
            tx_reg <= 1'b0; // [RL14]
         end
         if (core.xoff_seen || core.special_seen) begin
            xoff_reg <= 1'b1;
         end else if ((rd_source && src_code == SRC_XOFF) || core.xon_seen ||
                      core.char_in) begin
            xoff_reg <= 1'b0; // [RL15]
         end
         if ((cts_s2_reg && !cts_s3_reg && auto_cts) ||
             (rts_s2_reg && !rts_s3_reg && auto_rts)) begin
            flow_reg <= 1'b1; // [RL6] [RL11]
         end else if (rd_modem) begin
            flow_reg <= 1'b0; // [RL16]
         end
         ms_reg <= |modem_change; // [RL10]
         if (core.wake) begin
            wake_reg <= 1'b1;
         end else if (rd_source) begin
            wake_reg <= 1'b0; // [RL16]
         end
      end
   end

   // Priority encoder: only the highest enabled source is shown
   always_comb begin
      if (ls_reg && mask_reg[MSK_LS]) begin
         src_code = SRC_LS; // [RL7] [RL17]
      end else if (to_reg && mask_reg[MSK_RX]) begin
         src_code = SRC_TO;
      end else if (rx_hit && mask_reg[MSK_RX]) begin
         src_code = SRC_RX; // [RL1]
      end else if (tx_reg && mask_reg[MSK_TX]) begin
         src_code = SRC_TX;
      end else if (ms_reg && mask_reg[MSK_MS]) begin
         src_code = SRC_MS;
      end else if (xoff_reg && mask_reg[MSK_XOFF] && enh_enable) begin
         src_code = SRC_XOFF; // [RL5]
      end else if (flow_reg && (mask_reg[MSK_RTS] || mask_reg[MSK_CTS]) && enh_enable) begin
         src_code = SRC_FLOW;
      end else begin
         src_code = SRC_NONE; // [RL18]
      end
   end
   assign src_byte = {{2{fifo_enable}}, src_code}; // [RL19]

   // Read channel; one-cycle answer
   assign s_axi_arready = !rvalid_reg;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
         irq <= 1'b0;
      end else begin
         irq <= src_code != SRC_NONE;
         if (do_read) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            unique case (s_axi_araddr)
               ADDR_MASK: rdata_reg <= {24'h00_0000, mask_reg};
               ADDR_SOURCE: rdata_reg <= {24'h00_0000, src_byte};
               ADDR_LINE: rdata_reg <= {24'h00_0000, core.err_left, 7'h00};
               ADDR_MODEM: rdata_reg <= 32'h0000_0000;
               default: begin
                  rdata_reg <= 32'h0000_0000;
                  rresp_reg <= RESP_SLVERR;
               end
            endcase
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   p_rst_mask: assert property (@(posedge clock) $rose(rst_n) |-> mask_reg == 8'h00) // [RL23]
      else $error("mask not zero after reset");
   p_enh: assert property (@(posedge clock) disable iff (!rst_n)
      wr_mask && !enh_enable |=> mask_reg[7:4] == $past(mask_reg[7:4])) // [RL5]
      else $error("upper mask changed without enhanced enable");
   p_qen: assert property (@(posedge clock) disable iff (!rst_n)
      wr_qctrl && !wdata_reg[QC_EN] |=> !rx_fifo_reset && !tx_fifo_reset && !fifo_enable) // [RL20]
      else $error("queue control taken without enable");
   p_rstpulse: assert property (@(posedge clock) disable iff (!rst_n)
      rx_fifo_reset |=> !rx_fifo_reset) // [RL21]
      else $error("fifo reset did not self clear");
   p_top: assert property (@(posedge clock) disable iff (!rst_n)
      src_byte[7:6] == {2{fifo_enable}}) // [RL19]
      else $error("source top bits wrong");
   p_none: assert property (@(posedge clock) disable iff (!rst_n)
      src_code[0] == (src_code == SRC_NONE)) // [RL18]
      else $error("pending bit wrong");
   p_ls: assert property (@(posedge clock) disable iff (!rst_n)
      core.overrun && mask_reg[MSK_LS] |=> src_code == SRC_LS) // [RL3]
      else $error("overrun did not raise line interrupt");
   p_txclr: assert property (@(posedge clock) disable iff (!rst_n)
      wr_thold && !tx_hit && tx_empty_prev_reg |=> !tx_reg) // [RL14]
      else $error("transmit not cleared by holding write");
   p_irq: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 irq == ($past(src_code) != SRC_NONE)) // [RL7]
      else $error("irq mismatch");
endmodule

// File: logic/uifc_pkg.sv
// Package: register map, field positions, codes and timing for the UART interrupt/FIFO control
package uifc_pkg;
   localparam logic [3:0] ADDR_MASK = 4'h4;
   localparam logic [3:0] ADDR_SOURCE = 4'h8;
   localparam logic [3:0] ADDR_QCTRL = 4'h8;
   localparam logic [3:0] ADDR_LINE = 4'hC;
   localparam logic [3:0] ADDR_MODEM = 4'h0;
   localparam logic [3:0] ADDR_RHOLD = 4'h0;
   localparam logic [3:0] ADDR_THOLD = 4'h0;
   localparam int MSK_RX = 0;
   localparam int MSK_TX = 1;
   localparam int MSK_LS = 2;
   localparam int MSK_MS = 3;
   localparam int MSK_XOFF = 5;
   localparam int MSK_RTS = 6;
   localparam int MSK_CTS = 7;
   localparam int QC_EN = 0;
   localparam int QC_RXRST = 1;
   localparam int QC_TXRST = 2;
   localparam int QC_TXTRG = 4;
   localparam int QC_RXTRG = 6;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] MASK_LOW_BITS = 8'h0F;
   localparam logic [5:0] SRC_LS = 6'h06;
   localparam logic [5:0] SRC_TO = 6'h0C;
   localparam logic [5:0] SRC_RX = 6'h04;
   localparam logic [5:0] SRC_TX = 6'h02;
   localparam logic [5:0] SRC_MS = 6'h00;
   localparam logic [5:0] SRC_XOFF = 6'h10;
   localparam logic [5:0] SRC_FLOW = 6'h20;
   localparam logic [5:0] SRC_NONE = 6'h01;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam int FIFO_DEPTH = 16;
   // Timeout: four characters plus twelve bits, counted in bit times
   localparam int TO_CHARS = 4;
   localparam int TO_BITS = 12;
   typedef struct packed {
      logic char_in;
      logic char_out;
      logic overrun;
      logic char_err;
      logic err_left;
      logic xoff_seen;
      logic xon_seen;
      logic special_seen;
      logic wake;
      logic bit_tick;
   } uifc_core_t;
endpackage
